/* File: hw/pes_np_tracker.sv */
/*
  Counts nonposted requests issued and not yet completed and flags
  when any are outstanding.
  Assumes issue and done are single-cycle pulses in the core clock.
*/
`timescale 1ns/10ps
module pes_np_tracker
  import pes_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic npIssue,
  input wire logic npDone,
  output logic nonpostedOutstanding
);

  logic [PES_NP_CNT_W-1:0] npCnt_r;
  logic [PES_NP_CNT_W-1:0] npCnt_nxt;

  // saturate rather than wrap; a stray done at zero is ignored
  always_comb begin
    npCnt_nxt = npCnt_r;
    if (npIssue && !npDone && npCnt_r != PES_NP_CNT_MAX) begin
      npCnt_nxt = npCnt_r + PES_NP_CNT_ONE;
    end else if (npDone && !npIssue && npCnt_r != PES_NP_CNT_RST) begin
      npCnt_nxt = npCnt_r - PES_NP_CNT_ONE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      npCnt_r <= PES_NP_CNT_RST;
    end else begin
      npCnt_r <= npCnt_nxt;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      nonpostedOutstanding <= 1'b0;
    end else begin
      nonpostedOutstanding <= (npCnt_nxt != PES_NP_CNT_RST);
    end
  end

endmodule

/* File: hw/pes_pkg.sv */
/*
  Shared constants and types for the error status and link capability
  register bank: configuration offsets, field positions, reset values,
  fixed capability encodings and the carrier structs.
  Assumes a single core clock domain; no timing constants are needed.
*/
package pes_pkg;

  // ----------------------------------------------------------------
  // configuration offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] PES_DEV_CTRL_OFF = 8'h98;
  localparam logic [7:0] PES_DEV_STAT_OFF = 8'h9a;
  localparam logic [7:0] PES_LINK_CAP_OFF = 8'h9c;
  localparam logic [7:0] PES_LINK_CTRL_OFF = 8'ha0;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int PES_CTRL_FATAL_BIT = 2;
  localparam int PES_CTRL_NONFATAL_BIT = 1;
  localparam int PES_CTRL_COR_BIT = 0;
  localparam int PES_STAT_NONPOSTED_OUTSTANDING_BIT = 5;
  localparam int PES_STAT_AUX_BIT = 4;
  localparam int PES_STAT_UR_BIT = 3;
  localparam int PES_STAT_FATAL_BIT = 2;
  localparam int PES_STAT_NONFATAL_BIT = 1;
  localparam int PES_STAT_COR_BIT = 0;
  localparam int PES_LCTRL_CCC_BIT = 6;
  // status lives in the upper half of the control dword
  localparam int PES_STAT_LANE = 2;
  localparam int PES_CTRL_LANE = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] PES_CTRL_EN_RST = 3'h0;
  localparam logic [3:0] PES_STAT_FLAGS_RST = 4'h0;
  localparam logic PES_CCC_RST = 1'b0;
  localparam logic [2:0] PES_NONPOSTED_OUTSTANDING_MSG_RST = 3'h0;

  // ----------------------------------------------------------------
  // fixed link capability encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] PES_PORT_NUM = 8'h00;
  localparam logic [4:0] PES_LCAP_RSVD = 5'h00;
  localparam logic PES_CLOCK_REQUEST_PM_SUPPORTED_SUPPORTED = 1'b1;
  localparam logic [2:0] PES_L0S_EXIT_COMMON = 3'h3;
  localparam logic [2:0] PES_L0S_EXIT_ASYNC = 3'h4;
  localparam logic [1:0] PES_ACTIVE_PM_SUPPORT = 2'h3;
  localparam logic [5:0] PES_MAX_LANE_COUNT = 6'h01;
  localparam logic [3:0] PES_MAX_LINK_RATE = 4'h1;

  // outstanding nonposted counter width
  localparam int PES_NP_CNT_W = 6;
  localparam logic [PES_NP_CNT_W-1:0] PES_NP_CNT_RST = 6'h00;
  localparam logic [PES_NP_CNT_W-1:0] PES_NP_CNT_MAX = 6'h3f;
  localparam logic [PES_NP_CNT_W-1:0] PES_NP_CNT_ONE = 6'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    PES_MSG_IDLE = 1'b0,
    PES_MSG_SEND = 1'b1
  } pes_msg_state_e;

  // encoding equals the index of the matching enable bit
  typedef enum logic [1:0] {
    PES_MSG_COR = 2'h0,
    PES_MSG_NONFATAL = 2'h1,
    PES_MSG_FATAL = 2'h2
  } pes_msg_type_e;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] byteEn;
    logic [31:0] wdata;
  } pes_cfg_req_s;

  typedef struct packed {
    logic fatalErr;
    logic nonfatalErr;
    logic corErr;
    logic unsupportedReq;
    logic npIssue;
    logic npDone;
  } pes_evt_s;

  typedef struct packed {
    logic [7:0] portNum;
    logic [4:0] rsvd;
    logic clockRequestPmSupported;
    logic [2:0] l1ExitTime;
    logic [2:0] l0sExitTime;
    logic [1:0] activePmSupport;
    logic [5:0] maxLaneCount;
    logic [3:0] maxLinkRate;
  } pes_link_cap_s;

endpackage

/* File: hw/pes_regs.sv */
/*
  Error reporting enables, device status and link capability registers
  of the bridge, reached through a configuration access port, plus the
  upstream error message request handshake.
  Assumes one core clock, event inputs synchronous single-cycle pulses,
  and a root-complex side that accepts messages with msgReady.
*/
// Contract
// - fatal enable set sends fatal message on fatal event; else none.
// - nonfatal enable set sends nonfatal message on event; else none.
// - correctable enable set sends correctable message on event.
// - status bits 15 to 6 always read zero.
// - status bit 5 high while any nonposted request awaits completion.
// - status bit 4 shows auxiliary power present.
// - status bit 3 set on each unsupported request received.
// - status bit 2 set when a fatal error is detected.
// - status bit 1 set when a nonfatal error is detected.
// - status bit 0 set when a correctable error is detected.
// - capability port number field reads constant 00h.
// - capability bits 23 to 19 read zero.
// - capability bit 18 reads one, clock request power management.
// - L1 exit field picks diagnostic field by common clock setting.
// - L0s exit field reads 011b common clock, 100b asynchronous.
// - active power management support field reads 11b.
// - maximum lane count field reads 000001b.
// - maximum link rate field reads 1h.
// - link control bit 6 is the common clock setting, default 0.
`timescale 1ns/10ps
module pes_regs
  import pes_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input pes_cfg_req_s cfgReq,
  input pes_evt_s evt,
  input wire logic auxPowerPresent,
  input wire logic [2:0] diagL1ExitA,
  input wire logic [2:0] diagL1ExitB,
  input wire logic msgReady,
  output logic [31:0] cfgRdata_r,
  output logic cfgAck_r,
  output logic msgValid_r,
  output pes_msg_type_e msgType_r
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic wordHit(input logic [7:0] addr,
                                   input logic [7:0] off);
    return addr[7:2] == off[7:2];
  endfunction

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic fatalReportEn_r;
  logic nonfatalReportEn_r;
  logic correctableReportEn_r;
  logic commonClock_r;
  logic [3:0] errSeen_r;
  logic [3:0] errSeen_nxt;
  logic [2:0] pendMsg_r;
  logic [2:0] pendMsg_nxt;
  pes_msg_state_e msgState_r;
  logic nonpostedOutstanding;
  pes_link_cap_s linkCap;
  logic [15:0] devStatus;
  logic [15:0] devCtrl;
  logic [31:0] rdMux;
  logic ctrlWrite;
  logic statWrite;
  logic lctrlWrite;
  logic [3:0] errSet;
  logic [3:0] errClr;
  logic [2:0] msgSet;
  logic [2:0] msgClr;

  assign ctrlWrite = cfgReq.wr && wordHit(cfgReq.addr, PES_DEV_CTRL_OFF)
                     && cfgReq.byteEn[PES_CTRL_LANE];
  assign statWrite = cfgReq.wr && wordHit(cfgReq.addr, PES_DEV_STAT_OFF)
                     && cfgReq.byteEn[PES_STAT_LANE];
  assign lctrlWrite = cfgReq.wr && wordHit(cfgReq.addr, PES_LINK_CTRL_OFF)
                      && cfgReq.byteEn[PES_CTRL_LANE];

  // ----------------------------------------------------------------
  // outstanding nonposted tracking
  // ----------------------------------------------------------------
  pes_np_tracker u_np (
    .clock(clock),
    .rst(rst),
    .npIssue(evt.npIssue),
    .npDone(evt.npDone),
    .nonpostedOutstanding(nonpostedOutstanding)
  );

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      {fatalReportEn_r, nonfatalReportEn_r, correctableReportEn_r}
        <= PES_CTRL_EN_RST;
    end else if (ctrlWrite) begin
      fatalReportEn_r <= cfgReq.wdata[PES_CTRL_FATAL_BIT];
      nonfatalReportEn_r <= cfgReq.wdata[PES_CTRL_NONFATAL_BIT];
      correctableReportEn_r <= cfgReq.wdata[PES_CTRL_COR_BIT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      commonClock_r <= PES_CCC_RST;
    end else if (lctrlWrite) begin
      commonClock_r <= cfgReq.wdata[PES_LCTRL_CCC_BIT];
    end
  end

  // ----------------------------------------------------------------
  // detected error flags
  // ----------------------------------------------------------------
  // unsupported request, fatal, nonfatal and correctable flags
  assign errSet = {evt.unsupportedReq, evt.fatalErr,
                   evt.nonfatalErr, evt.corErr};
  // status word sits in lane 2, so flags come from wdata[19:16]
  assign errClr = statWrite ? cfgReq.wdata[19:16] : 4'h0;

  // write one to clear, set wins
  always_comb begin
    errSeen_nxt = (errSeen_r & ~errClr) | errSet;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      errSeen_r <= PES_STAT_FLAGS_RST;
    end else begin
      errSeen_r <= errSeen_nxt;
    end
  end

  // ----------------------------------------------------------------
  // upstream error messages
  // ----------------------------------------------------------------
  // fatal, nonfatal and correctable messages each gated by their own enable
  assign msgSet = {evt.fatalErr & fatalReportEn_r,
                   evt.nonfatalErr & nonfatalReportEn_r,
                   evt.corErr & correctableReportEn_r};

  always_comb begin
    msgClr = 3'h0;
    if (msgState_r == PES_MSG_SEND && msgReady) begin
      msgClr[msgType_r] = 1'b1;
    end
    // a new event of the same kind during acceptance is kept
    pendMsg_nxt = (pendMsg_r & ~msgClr) | msgSet;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pendMsg_r <= PES_NONPOSTED_OUTSTANDING_MSG_RST;
    end else begin
      pendMsg_r <= pendMsg_nxt;
    end
  end

  // one message in flight; fatal first when several wait
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      msgState_r <= PES_MSG_IDLE;
      msgValid_r <= 1'b0;
      msgType_r <= PES_MSG_COR;
    end else begin
      case (msgState_r)
        PES_MSG_IDLE: begin
          if (pendMsg_r != 3'h0) begin
            msgState_r <= PES_MSG_SEND;
            msgValid_r <= 1'b1;
            if (pendMsg_r[PES_CTRL_FATAL_BIT]) begin
              msgType_r <= PES_MSG_FATAL;
            end else if (pendMsg_r[PES_CTRL_NONFATAL_BIT]) begin
              msgType_r <= PES_MSG_NONFATAL;
            end else begin
              msgType_r <= PES_MSG_COR;
            end
          end
        end
        PES_MSG_SEND: begin
          if (msgReady) begin
            msgState_r <= PES_MSG_IDLE;
            msgValid_r <= 1'b0;
          end
        end
        default: begin
          msgState_r <= PES_MSG_IDLE;
          msgValid_r <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read side
  // ----------------------------------------------------------------
  // link capability fields
  always_comb begin
    linkCap.portNum = PES_PORT_NUM;
    linkCap.rsvd = PES_LCAP_RSVD;
    linkCap.clockRequestPmSupported = PES_CLOCK_REQUEST_PM_SUPPORTED_SUPPORTED;
    linkCap.l1ExitTime = commonClock_r ? diagL1ExitA : diagL1ExitB;
    linkCap.l0sExitTime = commonClock_r ? PES_L0S_EXIT_COMMON
                                        : PES_L0S_EXIT_ASYNC;
    linkCap.activePmSupport = PES_ACTIVE_PM_SUPPORT;
    linkCap.maxLaneCount = PES_MAX_LANE_COUNT;
    linkCap.maxLinkRate = PES_MAX_LINK_RATE;
  end

  always_comb begin
    devStatus = 16'h0000;
    devStatus[PES_STAT_NONPOSTED_OUTSTANDING_BIT] = nonpostedOutstanding;
    devStatus[PES_STAT_AUX_BIT] = auxPowerPresent;
    devStatus[3:0] = errSeen_r;
    devCtrl = 16'h0000;
    devCtrl[PES_CTRL_FATAL_BIT] = fatalReportEn_r;
    devCtrl[PES_CTRL_NONFATAL_BIT] = nonfatalReportEn_r;
    devCtrl[PES_CTRL_COR_BIT] = correctableReportEn_r;
  end

  // unmapped words answer with zero so probing never hangs
  always_comb begin
    rdMux = 32'h0000_0000;
    if (wordHit(cfgReq.addr, PES_DEV_CTRL_OFF)) begin
      rdMux = {devStatus, devCtrl};
    end else if (wordHit(cfgReq.addr, PES_LINK_CAP_OFF)) begin
      rdMux = linkCap;
    end else if (wordHit(cfgReq.addr, PES_LINK_CTRL_OFF)) begin
      rdMux[PES_LCTRL_CCC_BIT] = commonClock_r;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cfgRdata_r <= 32'h0000_0000;
      cfgAck_r <= 1'b0;
    end else begin
      cfgAck_r <= cfgReq.rd || cfgReq.wr;
      if (cfgReq.rd) begin
        cfgRdata_r <= rdMux;
      end else begin
        cfgRdata_r <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  logic rdCtrlWord;
  logic rdCapWord;
  assign rdCtrlWord = cfgReq.rd && wordHit(cfgReq.addr, PES_DEV_CTRL_OFF);
  assign rdCapWord = cfgReq.rd && wordHit(cfgReq.addr, PES_LINK_CAP_OFF);

  a_fatal_msg_gate: assert property (
    $rose(pendMsg_r[PES_CTRL_FATAL_BIT]) |->
      $past(evt.fatalErr && fatalReportEn_r))
    else $error("fatal message queued without enabled event");
  a_nonfatal_msg_gate: assert property (
    evt.nonfatalErr && nonfatalReportEn_r |=>
      pendMsg_r[PES_CTRL_NONFATAL_BIT] || msgType_r == PES_MSG_NONFATAL)
    else $error("nonfatal message not queued");
  a_cor_msg_quiet: assert property (
    !correctableReportEn_r && !pendMsg_r[PES_CTRL_COR_BIT] |=>
      !pendMsg_r[PES_CTRL_COR_BIT])
    else $error("correctable message queued while disabled");
  a_status_rsvd_zero: assert property (
    rdCtrlWord |=> cfgRdata_r[31:22] == 10'h000)
    else $error("reserved status bits not zero");
  a_nonposted_outstanding_follows: assert property (
    evt.npIssue && !evt.npDone |=> nonpostedOutstanding)
    else $error("pending flag missing after issue");
  a_aux_power: assert property (
    rdCtrlWord |=> cfgRdata_r[16 + PES_STAT_AUX_BIT] == $past(auxPowerPresent))
    else $error("aux power bit wrong");
  a_err_flag_set: assert property (
    evt.unsupportedReq ##1 cfgReq.rd && wordHit(cfgReq.addr,
      PES_DEV_STAT_OFF) |=> cfgRdata_r[16 + PES_STAT_UR_BIT])
    else $error("unsupported request flag not set");
  a_err_set_wins: assert property (
    (evt.fatalErr && statWrite && cfgReq.wdata[18]) |=>
      errSeen_r[PES_STAT_FATAL_BIT])
    else $error("fatal flag lost to clear");
  a_err_hold: assert property (
    errSeen_r[PES_STAT_COR_BIT] && !(statWrite && cfgReq.wdata[16]) |=>
      errSeen_r[PES_STAT_COR_BIT])
    else $error("correctable flag dropped without clear");
  a_linkcap_const: assert property (
    rdCapWord |=> cfgRdata_r[31:18] == 14'h0001 &&
      cfgRdata_r[11:0] == 12'hc11)
    else $error("link capability constant fields wrong");
  a_exit_select: assert property (
    rdCapWord |=> cfgRdata_r[17:12] == ($past(commonClock_r) ?
      {$past(diagL1ExitA), 3'h3} : {$past(diagL1ExitB), 3'h4}))
    else $error("exit time fields wrong");
  a_msg_stable: assert property (
    msgValid_r && !msgReady |=> msgValid_r && $stable(msgType_r))
    else $error("message request dropped before accept");

  c_fatal_sent: cover property (msgValid_r && msgReady &&
    msgType_r == PES_MSG_FATAL);
  c_flag_cleared: cover property (errSeen_r[0] ##1 !errSeen_r[0]);
  c_common_read: cover property (commonClock_r && rdCapWord);

endmodule

/* File: verification/pes_root_model.sv */
/*
  Behavioural model of the root complex that takes upstream error
  messages from the register bank over a valid/ready handshake.
  Assumes the bank holds valid and type until ready is seen high.
*/
`timescale 1ns/10ps
module pes_root_model
  import pes_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic msgValid_r,
  input pes_msg_type_e msgType_r,
  input wire logic [3:0] stall,
  output logic msgReady_r,
  output logic [7:0] rxCount_r,
  output pes_msg_type_e rxType_r
);
  logic [3:0] waitCnt_r;

  // ----------------------------------------------------------------
  // accept after a programmable stall
  // ----------------------------------------------------------------
  // ready only moves after an edge, and drops right after an accept
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      msgReady_r <= 1'b0;
      waitCnt_r <= 4'h0;
      rxCount_r <= 8'h00;
      rxType_r <= PES_MSG_COR;
    end else if (msgValid_r && msgReady_r) begin
      msgReady_r <= 1'b0;
      waitCnt_r <= 4'h0;
      rxCount_r <= rxCount_r + 8'h01;
      rxType_r <= msgType_r;
    end else if (msgValid_r && waitCnt_r >= stall) begin
      msgReady_r <= 1'b1;
    end else if (msgValid_r) begin
      waitCnt_r <= waitCnt_r + 4'h1;
    end
  end
endmodule

/* File: verification/tb.sv */
/*
  Self-checking bench for the error status and link capability bank.
  Assumes the config port acks one cycle after each request and the
  root model beside it takes the error messages.
*/
`timescale 1ns/10ps
module tb;
  import pes_pkg::*;

  typedef struct packed {
    logic ccc;
    logic [2:0] a;
    logic [2:0] b;
    logic aux;
    logic [31:0] cap;
  } pes_row_s;

  localparam pes_row_s ROWS [4] = '{
    '{1'b0, 3'h5, 3'h2, 1'b1, 32'h00054c11},
    '{1'b1, 3'h5, 3'h2, 1'b0, 32'h0006bc11},
    '{1'b0, 3'h7, 3'h7, 1'b1, 32'h0007cc11},
    '{1'b1, 3'h0, 3'h7, 1'b0, 32'h00043c11}
  };
  // fields that stay fixed whatever the clock setting and diag inputs
  localparam logic [31:0] CAP_M = 32'hfffc0fff;
  localparam logic [31:0] CAP_K = 32'h00040c11;

  logic clock = 1'b0;
  logic rst = 1'b1;
  pes_cfg_req_s cfgReq = '0;
  pes_evt_s evt = '0;
  logic auxPowerPresent = 1'b0;
  logic [2:0] diagL1ExitA = 3'h0;
  logic [2:0] diagL1ExitB = 3'h0;
  logic [3:0] stall = 4'h0;
  logic msgReady;
  logic [31:0] cfgRdata_r;
  logic cfgAck_r;
  logic msgValid_r;
  pes_msg_type_e msgType_r;
  logic [7:0] rxCount;
  pes_msg_type_e rxType;
  int mismatches = 0;
  int compares = 0;
  logic [31:0] rd;

  always #5 clock = ~clock;

  pes_regs dut_u (
    .clock(clock),
    .rst(rst),
    .cfgReq(cfgReq),
    .evt(evt),
    .auxPowerPresent(auxPowerPresent),
    .diagL1ExitA(diagL1ExitA),
    .diagL1ExitB(diagL1ExitB),
    .msgReady(msgReady),
    .cfgRdata_r(cfgRdata_r),
    .cfgAck_r(cfgAck_r),
    .msgValid_r(msgValid_r),
    .msgType_r(msgType_r)
  );

  pes_root_model root_u (
    .clock(clock),
    .rst(rst),
    .msgValid_r(msgValid_r),
    .msgType_r(msgType_r),
    .stall(stall),
    .msgReady_r(msgReady),
    .rxCount_r(rxCount),
    .rxType_r(rxType)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check_reg(input string name, input logic [31:0] exp,
                           input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask

  task automatic check_msg(input string name, input pes_msg_type_e exp,
                           input pes_msg_type_e got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask

  // request held one cycle, answer looked at in the ack cycle
  task automatic cfg_access(input logic wr, input logic [7:0] addr,
                            input logic [3:0] be, input logic [31:0] data,
                            output logic [31:0] rdata);
    int n;
    n = 0;
    @(posedge clock);
    cfgReq <= '{rd: !wr, wr: wr, addr: addr, byteEn: be, wdata: data};
    @(posedge clock);
    cfgReq <= '0;
    #1;
    while (cfgAck_r !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (cfgAck_r !== 1'b1) begin
      mismatches++;
      stop_test();
    end
    rdata = cfgRdata_r;
  endtask

  task automatic pulse(input logic [5:0] bits);
    @(posedge clock);
    evt <= pes_evt_s'(bits);
    @(posedge clock);
    evt <= '0;
  endtask

  task automatic wait_msg(input pes_msg_type_e exp);
    int n;
    logic [7:0] c0;
    c0 = rxCount;
    n = 0;
    while (rxCount === c0 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (rxCount === c0) begin
      mismatches++;
      stop_test();
    end
    check_msg("message type", exp, rxType);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cfg_access(1'b0, PES_DEV_CTRL_OFF, 4'hf, 32'h0, rd);
    check_reg("ctrl status reset", 32'h0, rd); // reset zero
    cfg_access(1'b0, PES_LINK_CTRL_OFF, 4'hf, 32'h0, rd);
    check_reg("link ctrl reset", 32'h0, rd); // clock default
    cfg_access(1'b0, 8'h40, 4'hf, 32'h0, rd);
    check_reg("unmapped read", 32'h0, rd);
    foreach (ROWS[i]) begin
      @(posedge clock);
      auxPowerPresent <= ROWS[i].aux;
      diagL1ExitA <= ROWS[i].a;
      diagL1ExitB <= ROWS[i].b;
      cfg_access(1'b1, PES_LINK_CTRL_OFF, 4'h1,
                 {25'h0, ROWS[i].ccc, 6'h0}, rd);
      cfg_access(1'b0, PES_LINK_CAP_OFF, 4'hf, 32'h0, rd);
      check_reg("cap", ROWS[i].cap, rd);
      check_reg("cap k", CAP_K, rd & CAP_M);
      cfg_access(1'b0, PES_LINK_CTRL_OFF, 4'hf, 32'h0, rd);
      check_reg("link ctrl", {25'h0, ROWS[i].ccc, 6'h0}, rd);
      cfg_access(1'b0, PES_DEV_STAT_OFF, 4'hf, 32'h0, rd);
      check_reg("aux power", {11'h0, ROWS[i].aux, 20'h0}, rd);
    end
    @(posedge clock);
    auxPowerPresent <= 1'b0;
    // all errors with every enable off: flags only, no message
    pulse(6'h3c);
    repeat (6) @(posedge clock);
    check_reg("silent", 32'h0, {24'h0, rxCount});
    cfg_access(1'b0, PES_DEV_STAT_OFF, 4'hf, 32'h0, rd);
    check_reg("flags", 32'h000f0000, rd);
    cfg_access(1'b1, PES_DEV_STAT_OFF, 4'h4, 32'h0, rd);
    cfg_access(1'b0, PES_DEV_STAT_OFF, 4'hf, 32'h0, rd);
    check_reg("zero write", 32'h000f0000, rd);
    cfg_access(1'b1, PES_DEV_STAT_OFF, 4'h4, 32'h00050000, rd);
    cfg_access(1'b0, PES_DEV_STAT_OFF, 4'hf, 32'h0, rd);
    check_reg("partial clear", 32'h000a0000, rd);
    // only the nonfatal enable on
    cfg_access(1'b1, PES_DEV_CTRL_OFF, 4'h1, 32'h2, rd);
    pulse(6'h38);
    wait_msg(PES_MSG_NONFATAL);
    repeat (8) @(posedge clock);
    check_reg("one message", 32'h1, {24'h0, rxCount});
    // all enables on, slow partner, priority order
    cfg_access(1'b1, PES_DEV_CTRL_OFF, 4'h1, 32'h7, rd);
    cfg_access(1'b0, PES_DEV_CTRL_OFF, 4'hf, 32'h0, rd);
    check_reg("enables", 32'h000f0007, rd);
    @(posedge clock);
    stall <= 4'h5;
    pulse(6'h38);
    wait_msg(PES_MSG_FATAL);
    wait_msg(PES_MSG_NONFATAL);
    wait_msg(PES_MSG_COR);
    // outstanding nonposted tracking
    cfg_access(1'b1, PES_DEV_STAT_OFF, 4'h4, 32'h000f0000, rd);
    pulse(6'h02);
    pulse(6'h02);
    cfg_access(1'b0, PES_DEV_STAT_OFF, 4'hf, 32'h0, rd);
    check_reg("pending two", 32'h00200007, rd);
    pulse(6'h01);
    cfg_access(1'b0, PES_DEV_STAT_OFF, 4'hf, 32'h0, rd);
    check_reg("pending one", 32'h00200007, rd);
    pulse(6'h01);
    cfg_access(1'b0, PES_DEV_STAT_OFF, 4'hf, 32'h0, rd);
    check_reg("pending none", 32'h00000007, rd);
    // event and its clear in one cycle: the event must win
    @(posedge clock);
    evt <= pes_evt_s'(6'h24);
    cfgReq <= '{rd: 1'b0, wr: 1'b1, addr: PES_DEV_STAT_OFF, byteEn: 4'h4,
                wdata: 32'h000c0000};
    @(posedge clock);
    evt <= '0;
    cfgReq <= '{rd: 1'b1, wr: 1'b0, addr: PES_DEV_STAT_OFF, byteEn: 4'hf,
                wdata: 32'h0};
    @(posedge clock);
    cfgReq <= '0;
    #1;
    check_reg("set wins", 32'h000c0007, cfgRdata_r);
    check_reg("read ack", 32'h1, {31'h0, cfgAck_r});
    @(posedge clock);
    #1;
    check_reg("rdata idle", 32'h0, cfgRdata_r);
    wait_msg(PES_MSG_FATAL);
    // reset in mid-run clears enables, flags and the clock setting
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cfg_access(1'b0, PES_DEV_CTRL_OFF, 4'hf, 32'h0, rd);
    check_reg("second reset", 32'h0, rd);
    cfg_access(1'b0, PES_LINK_CTRL_OFF, 4'hf, 32'h0, rd);
    check_reg("ccc reset", 32'h0, rd);
    stop_test();
  end
endmodule
